// >>> port_arb_pkg.sv
/*
  Shared constants for the shared pin group: port/arbiter mux.
  Assumes a single 40 MHz core clock and synchronous active-high reset.
*/
package port_arb_pkg;
  // ==========================================================
  // Strap and widths
  localparam int STRAP_BIT = 7;
  localparam logic STRAP_PORT_MODE = 1'b1;
  localparam int NUM_CS = 3;
  localparam int NUM_MASTERS = 5;
  localparam int SELF_MASTER = 4;
  localparam int PME_STATUS_BIT = 15;
  localparam int PME_ENABLE_BIT = 8;
  localparam int CS_PME = 1;
  // ==========================================================
  // Port cycle timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_COUNT = 4'(STROBE_CYCLES);
  // Address windows for the three selects, byte address bits [23:22]
  localparam logic [1:0] CS_WINDOW0 = 2'h1;
  localparam logic [1:0] CS_WINDOW1 = 2'h2;
  localparam logic [1:0] CS_WINDOW2 = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_DONE} port_state_e;
endpackage

// >>> periph_port_arbiter_mux.sv
/*
  Shared pin group: strap-selected parallel peripheral port or five-master bus arbiter.
  Assumes inputs synchronous to ref_clk; processor side issues one cycle request at a time.
*/
`timescale 1ns/1ps

// What this block does
// - strap bit 7 caught at reset release; 1 port mode, 0 arbiter mode
// - port serves 8 and 16 bit peripherals, address and data from processor
// - buffer direction output low throughout port writes, high at other times in port mode
// - read strobe low for port reads; peripheral drives data meanwhile
// - write strobe low for port writes; peripheral takes data meanwhile
// - output chip selects go low for accesses in their address window
// - unused chip selects may be inputs used as interrupt sources
// - select 1 as output gives power event when status 15 and enable 8 set
// - arbiter grants highest priority requester of five masters
// - own grant driven on bus-request pin, looped back by board
module periph_port_arbiter_mux
  import port_arb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reset_strap_bit7,
  input wire logic port_req,
  input wire logic port_write,
  input wire logic port_wide,
  input wire logic [31:0] port_addr,
  input wire logic [15:0] port_wdata,
  output logic port_done,
  output logic [15:0] port_rdata,
  input wire logic [15:0] periph_data_in,
  output logic [15:0] periph_data_out,
  output logic periph_data_oe,
  input wire logic [NUM_CS-1:0] cs_as_output,
  input wire logic pme_mode,
  input wire logic [15:0] power_ctrl_status,
  input wire logic self_req,
  output logic port_mode,
  output logic port_buffer_dir_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  input wire logic [NUM_CS-1:0] chip_sel_n_in,
  output logic [NUM_CS-1:0] chip_sel_n_out,
  output logic [NUM_CS-1:0] chip_sel_oe,
  output logic [NUM_CS-1:0] cs_irq,
  output logic grant0_n,
  input wire logic req3_n,
  output logic bus_req_n,
  output logic [NUM_MASTERS-1:0] grant_vec
);

  // ==========================================================
  // Strap capture
  logic strap_seen;
  logic next_strap_seen;
  logic next_port_mode;
  always_comb
  begin
    next_strap_seen = strap_seen;
    next_port_mode = port_mode;
    if (rst)
    begin
      next_strap_seen = 1'b0;
      next_port_mode = 1'b0;
    end
    else if (!strap_seen)
    begin
      // First clean edge after release latches the strap
      next_strap_seen = 1'b1;
      next_port_mode = (reset_strap_bit7 == STRAP_PORT_MODE);
    end
  end
  always_ff @(posedge ref_clk)
  begin
    strap_seen <= next_strap_seen;
    port_mode <= next_port_mode;
  end

  // ==========================================================
  // Port cycle engine
  function automatic logic [NUM_CS-1:0] decode_cs(input logic [31:0] a);
    logic [NUM_CS-1:0] hit;
    hit = '0;
    hit[0] = (a[23:22] == CS_WINDOW0);
    hit[1] = (a[23:22] == CS_WINDOW1);
    hit[2] = (a[23:22] == CS_WINDOW2);
    return hit;
  endfunction

  port_state_e state;
  port_state_e next_state;
  logic [3:0] count;
  logic [3:0] next_count;
  logic cyc_write;
  logic next_cyc_write;
  logic cyc_wide;
  logic next_cyc_wide;
  logic [NUM_CS-1:0] cyc_cs;
  logic [NUM_CS-1:0] next_cyc_cs;
  logic [15:0] wdata;
  logic [15:0] next_wdata;
  logic [15:0] next_rdata;
  logic next_done;
  always_comb
  begin
    next_state = state;
    next_count = count;
    next_cyc_write = cyc_write;
    next_cyc_wide = cyc_wide;
    next_cyc_cs = cyc_cs;
    next_wdata = wdata;
    next_rdata = port_rdata;
    next_done = 1'b0;
    unique case (state)
      ST_IDLE:
      begin
        if (port_req && port_mode && strap_seen)
        begin
          next_state = ST_STROBE;
          next_count = STROBE_COUNT;
          next_cyc_write = port_write;
          next_cyc_wide = port_wide;
          next_cyc_cs = decode_cs(port_addr) & cs_as_output;
          next_wdata = port_wide ? port_wdata : {8'h00, port_wdata[7:0]};
        end
      end
      ST_STROBE:
      begin
        next_count = count - 4'h1;
        if (count == 4'h1)
        begin
          next_state = ST_DONE;
          // Sample read data while the strobe is still low
          if (!cyc_write)
          begin
            next_rdata = cyc_wide ? periph_data_in : {8'h00, periph_data_in[7:0]};
          end
        end
      end
      ST_DONE:
      begin
        next_state = ST_IDLE;
        next_done = 1'b1;
      end
    endcase
    if (rst)
    begin
      next_state = ST_IDLE;
      next_count = 4'h0;
      next_cyc_write = 1'b0;
      next_cyc_wide = 1'b0;
      next_cyc_cs = '0;
      next_wdata = 16'h0000;
      next_rdata = 16'h0000;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    state <= next_state;
    count <= next_count;
    cyc_write <= next_cyc_write;
    cyc_wide <= next_cyc_wide;
    cyc_cs <= next_cyc_cs;
    wdata <= next_wdata;
    port_rdata <= next_rdata;
    port_done <= next_done;
  end

  // ==========================================================
  // Arbiter: fixed priority, master 0 highest, the device itself lowest
  logic [NUM_MASTERS-1:0] req_vec;
  logic [NUM_MASTERS-1:0] next_grant;
  always_comb
  begin
    req_vec = {self_req, ~req3_n, ~chip_sel_n_in};
    next_grant = '0;
    for (int i = NUM_MASTERS - 1; i >= 0; i--)
    begin
      if (req_vec[i])
      begin
        next_grant = '0;
        next_grant[i] = 1'b1;
      end
    end
    if (rst || port_mode || !strap_seen)
    begin
      next_grant = '0;
    end
  end

  // ==========================================================
  // Pin drivers
  logic active;
  logic next_dir_n;
  logic next_rd_n;
  logic next_wr_n;
  logic [NUM_CS-1:0] next_cs_n;
  logic [NUM_CS-1:0] next_cs_oe;
  logic [NUM_CS-1:0] next_cs_irq;
  logic next_grant0_n;
  logic next_bus_req_n;
  logic [15:0] next_data_out;
  logic next_data_oe;
  logic pme_out;
  always_comb
  begin
    active = (next_state == ST_STROBE);
    pme_out = pme_mode && power_ctrl_status[PME_STATUS_BIT]
      && power_ctrl_status[PME_ENABLE_BIT];
    next_dir_n = 1'b1;
    next_rd_n = 1'b1;
    next_wr_n = 1'b1;
    next_cs_n = '1;
    next_cs_oe = '0;
    next_cs_irq = '0;
    next_grant0_n = 1'b1;
    next_bus_req_n = 1'b1;
    next_data_out = next_wdata;
    next_data_oe = 1'b0;
    if (port_mode)
    begin
      next_data_oe = active && next_cyc_write;
      // Direction held across the whole write, strobe inside it
      next_dir_n = !(next_cyc_write && next_state != ST_IDLE);
      next_rd_n = !(active && !next_cyc_write);
      next_wr_n = !(active && next_cyc_write);
      next_cs_oe = cs_as_output;
      next_cs_n = active ? ~next_cyc_cs : '1;
      if (pme_mode && cs_as_output[CS_PME])
      begin
        next_cs_n[CS_PME] = !pme_out;
      end
      next_cs_irq = ~cs_as_output & ~chip_sel_n_in;
    end
    else if (strap_seen)
    begin
      next_grant0_n = !next_grant[0];
      next_dir_n = !next_grant[1];
      next_rd_n = !next_grant[2];
      next_wr_n = !next_grant[3];
      next_bus_req_n = !next_grant[SELF_MASTER];
    end
    if (rst)
    begin
      next_dir_n = 1'b1;
      next_rd_n = 1'b1;
      next_wr_n = 1'b1;
      next_cs_n = '1;
      next_cs_oe = '0;
      next_cs_irq = '0;
      next_grant0_n = 1'b1;
      next_bus_req_n = 1'b1;
      next_data_out = 16'h0000;
      next_data_oe = 1'b0;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    port_buffer_dir_n <= next_dir_n;
    read_strobe_n <= next_rd_n;
    write_strobe_n <= next_wr_n;
    chip_sel_n_out <= next_cs_n;
    chip_sel_oe <= next_cs_oe;
    cs_irq <= next_cs_irq;
    grant0_n <= next_grant0_n;
    bus_req_n <= next_bus_req_n;
    grant_vec <= next_grant;
    periph_data_out <= next_data_out;
    periph_data_oe <= next_data_oe;
  end

  // ==========================================================
  // Checks
  sequence write_strobe_s;
    !write_strobe_n;
  endsequence

  strobe_read_excl_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(read_strobe_n == 1'b0 && write_strobe_n == 1'b0 && port_mode))
    else $error("read and write strobes low together");
  dir_covers_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (port_mode and write_strobe_s) |-> !port_buffer_dir_n)
    else $error("buffer direction not set during write");
  dir_idle_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    (port_mode && state == ST_IDLE && $past(state) == ST_IDLE) |-> port_buffer_dir_n)
    else $error("buffer direction asserted while idle");
  strobe_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    (port_mode && $fell(write_strobe_n)) |-> !write_strobe_n [*4] ##1 write_strobe_n)
    else $error("write strobe width wrong");
  read_len_a: assert property (@(posedge ref_clk) disable iff (rst)
    (port_mode && $fell(read_strobe_n)) |-> !read_strobe_n [*4] ##1 read_strobe_n)
    else $error("read strobe width wrong");
  cs_with_strobe_a: assert property (@(posedge ref_clk) disable iff (rst)
    (port_mode && !chip_sel_n_out[0] && chip_sel_oe[0])
    |-> (!read_strobe_n || !write_strobe_n))
    else $error("chip select 0 low outside a strobe");
  cs_input_float_a: assert property (@(posedge ref_clk) disable iff (rst)
    (strap_seen && port_mode && !cs_as_output[2]) |=> !chip_sel_oe[2])
    else $error("input chip select driven");
  pme_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
    (strap_seen && port_mode && pme_mode && cs_as_output[CS_PME]
    && power_ctrl_status[PME_STATUS_BIT] && power_ctrl_status[PME_ENABLE_BIT])
    |=> !chip_sel_n_out[CS_PME])
    else $error("power event not driven");
  grant_onehot_a: assert property (@(posedge ref_clk) disable iff (rst)
    $onehot0(grant_vec))
    else $error("more than one grant");
  grant_prio_a: assert property (@(posedge ref_clk) disable iff (rst)
    (strap_seen && !port_mode && !chip_sel_n_in[0]) |=> (!grant0_n && bus_req_n))
    else $error("master 0 not granted first");
  self_grant_a: assert property (@(posedge ref_clk) disable iff (rst)
    (strap_seen && !port_mode && self_req && chip_sel_n_in == 3'h7 && req3_n)
    |=> !bus_req_n)
    else $error("own grant missing");
endmodule

// >>> periph_model.sv
/*
  Peripheral model for the port side: three select windows, one word each.
  Assumes strobes and selects come straight from the block's pins.
*/
`timescale 1ns/1ps
module periph_model
  import port_arb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [NUM_CS-1:0] chip_sel_n,
  input wire logic [15:0] data_out,
  output logic [15:0] data_in
);
  // ==========================================================
  // Storage and bus drive
  logic [15:0] store [NUM_CS];
  logic [15:0] last = 16'h0000;
  always @(posedge ref_clk)
  begin
    for (int i = 0; i < NUM_CS; i++)
      if (!write_strobe_n && !chip_sel_n[i]) store[i] <= data_out;
    last <= data_in;
  end
  // Released bus toggles so a stale value can never pass as read data
  always @*
  begin
    data_in = ~last;
    for (int i = 0; i < NUM_CS; i++)
      if (!read_strobe_n && !chip_sel_n[i]) data_in = store[i];
  end
endmodule

// >>> periph_port_arbiter_mux_bench.sv
/*
  Self-checking bench for the port/arbiter pin group.
  Assumes periph_model on the port pins; bench drives requests at falling edges.
*/
`timescale 1ns/1ps
module periph_port_arbiter_mux_bench;
  import port_arb_pkg::*;
  // ==========================================================
  // Signals
  logic ref_clk = 0, rst = 1, strap = 1, port_req = 0, port_write = 0, port_wide = 0;
  logic pme_mode = 0, self_req = 0, req3_n = 1;
  logic [31:0] port_addr = 32'h0;
  logic [15:0] port_wdata = 16'h0, power_ctrl_status = 16'h0;
  logic [NUM_CS-1:0] cs_as_output = 3'h7, cs_ext = 3'h7;
  logic port_done, port_mode, dir_n, rd_n, wr_n, grant0_n, bus_req_n, data_oe;
  logic [15:0] port_rdata, data_in, data_out;
  logic [NUM_CS-1:0] cs_in, cs_out, cs_oe, cs_irq;
  logic [NUM_MASTERS-1:0] grant_vec;
  int err_count = 0, tests_run = 0;
  always #12.5 ref_clk = ~ref_clk;
  // Pin level from whoever drives it
  assign cs_in = (cs_oe & cs_out) | (~cs_oe & cs_ext);
  periph_port_arbiter_mux dut (.ref_clk(ref_clk), .rst(rst), .reset_strap_bit7(strap),
    .port_req(port_req), .port_write(port_write), .port_wide(port_wide),
    .port_addr(port_addr), .port_wdata(port_wdata), .port_done(port_done),
    .port_rdata(port_rdata), .periph_data_in(data_in), .periph_data_out(data_out),
    .periph_data_oe(data_oe), .cs_as_output(cs_as_output), .pme_mode(pme_mode),
    .power_ctrl_status(power_ctrl_status), .self_req(self_req), .port_mode(port_mode),
    .port_buffer_dir_n(dir_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .chip_sel_n_in(cs_in), .chip_sel_n_out(cs_out), .chip_sel_oe(cs_oe),
    .cs_irq(cs_irq), .grant0_n(grant0_n), .req3_n(req3_n), .bus_req_n(bus_req_n),
    .grant_vec(grant_vec));
  periph_model model (.ref_clk(ref_clk), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .chip_sel_n(cs_in), .data_out(data_out), .data_in(data_in));
  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    rst = 1;
    strap = s;
    repeat (4) @(negedge ref_clk);
    chk({rd_n, wr_n, dir_n, cs_oe}, 6'h38);
    rst = 0;
    @(negedge ref_clk);
    chk(port_mode, s);
  endtask
  // One port cycle; strobe width, selects, direction and latency judged on the way
  task automatic port_cycle(input logic w, input logic wide, input logic [1:0] win,
                            input logic [15:0] wd, input logic [15:0] exp_rd);
    int n;
    int lo;
    logic [2:0] cs_exp;
    cs_exp = ~(3'h1 << (win - 2'h1));
    port_req = 1;
    port_write = w;
    port_wide = wide;
    port_addr = {8'h00, win, 22'h0};
    port_wdata = wd;
    @(negedge ref_clk);
    port_req = 0;
    n = 0;
    lo = 0;
    while (port_done !== 1'b1 && n < 20)
    begin
      if ((w ? wr_n : rd_n) === 1'b0)
      begin
        lo++;
        chk(cs_out, cs_exp);
        chk({dir_n, data_oe}, {~w, w});
        chk(w ? rd_n : wr_n, 1'b1);
      end
      else
        chk(dir_n, !w);
      @(negedge ref_clk);
      n++;
    end
    if (n >= 20)
    begin
      err_count++;
      end_of_test();
    end
    chk({dir_n, data_oe}, 2'h2);
    chk(lo, STROBE_COUNT);
    chk(n, 5);
    if (!w) chk(port_rdata, exp_rd);
    $display("port cycle done: write %0d window %0d", w, win);
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_port();
    port_cycle(1, 1, 2'h1, 16'hbeef, 16'h0);
    port_cycle(1, 0, 2'h3, 16'h1234, 16'h0);
    port_cycle(0, 1, 2'h1, 16'h0, 16'hbeef);
    port_cycle(0, 0, 2'h3, 16'h0, 16'h0034);
  endtask
  task automatic test_pins();
    pme_mode = 1;
    power_ctrl_status = 16'h8100;
    @(negedge ref_clk);
    chk(cs_out[CS_PME], 1'b0);
    power_ctrl_status = 16'h8000;
    @(negedge ref_clk);
    chk(cs_out[CS_PME], 1'b1);
    power_ctrl_status = 16'h0100;
    pme_mode = 0;
    cs_as_output = 3'h4;
    cs_ext = 3'h5;
    @(negedge ref_clk);
    chk(cs_oe, 3'h4);
    // The pin only shows the outside level once the select has turned round
    @(negedge ref_clk);
    chk(cs_irq, 3'h2);
    $display("pin direction and power event done");
  endtask
  // Each step up to the empty one drops the granted master; the last raises masters 1 and 3 from none
  task automatic test_arbiter();
    logic [4:0] reqs [7] = '{5'h1f, 5'h1e, 5'h1c, 5'h18, 5'h10, 5'h00, 5'h0a};
    logic [4:0] exp;
    foreach (reqs[k])
    begin
      {self_req, req3_n, cs_ext} = {reqs[k][4], ~reqs[k][3:0]};
      exp = reqs[k] & (~reqs[k] + 5'h1);
      @(negedge ref_clk);
      chk(cs_oe, 3'h0);
      chk(grant_vec, exp);
      chk({bus_req_n, wr_n, rd_n, dir_n, grant0_n}, 5'(~exp));
    end
    $display("arbiter priority done");
  endtask
  initial
  begin
    @(negedge ref_clk);
    do_reset(1);
    test_port();
    test_pins();
    cs_as_output = 3'h7;
    do_reset(0);
    test_arbiter();
    end_of_test();
  end
endmodule
